// ===== rtl/usr_rx_top.sv
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/100ps
// Overview of operation
// R01: start accepted if two of samples 3/5/7 low
// R02: one high start sample sets noise
// R03: failed start verify restarts the search
// R04: data bit is majority of samples 8/9/10
// R05: disagreeing data samples set noise
// R06: high late start samples only add noise
// R07: stop majority low frames error, disagreement noise
// R08: framing error posts with receive full
// R09: break character sets framing error
// R10: falling edges inside character resync counter
// R11: sixteen ticks per bit, stop at tick ten
// R12: one stop sample off noise, more framing
// R13: standby suppresses receiver interrupt requests
// R14: address mark wakes and sets full
// R15: waking idle sets neither idle nor full
// R16: idle count starts after start or stop
// R17: standby set on idle line wakes
// R18: full on transfer, irq when enabled
// R19: idle after 10/11 high bits, irq enabled
// R20: oversample clock is sixteen times baud
// R21: start edge is low after three highs
// R22: wake select one address, zero idle
// R23: idle start select one stop, zero start
// R24: noise accumulates, posts with receive full
module usr_rx_top import usr_pkg::*; (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // serial line
  input wire logic rxd_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // interrupt requests
  output logic rx_irq_o,
  output logic idle_irq_o
);
  usr_rx_state_t state_reg;
  logic rx;
  logic tick;
  logic [5:0] ctrl_reg;
  logic [15:0] baud_reg;
  logic rx_standby_ctrl_reg;
  logic [4:0] rt_cnt_reg;
  logic [4:0] rt_now;
  logic [2:0] hist_reg;
  logic [1:0] smp_reg;
  logic [2:0] vote_in;
  logic [3:0] bit_idx_reg;
  logic [8:0] shift_reg;
  logic last_bit_reg;
  logic rx_prev_reg;
  logic noise_acc_reg;
  logic [8:0] serial_data_buffer_reg;
  logic rx_full_flag_reg;
  logic framing_error_flag_reg;
  logic noise_flag_reg;
  logic idle_flag_reg;
  logic [7:0] idle_cnt_reg;
  logic line_idle_prev_reg;
  logic wake_sel;
  logic idle_count_start_sel;
  logic char9;
  logic rx_en;
  logic fall;
  logic resync;
  logic bit_end;
  logic start_check;
  logic decide;
  logic char_done;
  logic char_bit;
  logic accept;
  logic addr_wake;
  logic [7:0] idle_thr;
  logic line_idle;
  logic idle_evt;
  logic rd_stat;
  logic rd_data;

  assign wake_sel = ctrl_reg[CTRL_WAKE];
  assign idle_count_start_sel = ctrl_reg[CTRL_IDLE_START];
  assign char9 = ctrl_reg[CTRL_CHAR9];
  assign rx_en = ctrl_reg[CTRL_ENABLE];

  usr_sync2 u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .d_i(rxd_i),
    .q_o(rx)
  );

  usr_rt_div u_div (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .en_i(rx_en),
    .div_i(baud_reg),
    .tick_o(tick)
  );

  // sample decode on each oversample tick
  assign rt_now = rt_cnt_reg + RT_FIRST;
  assign vote_in = {smp_reg, rx};
  assign fall = tick && rx_prev_reg && !rx;
  // only a bit that decided high can be followed by a real edge
  assign resync = fall && last_bit_reg && (state_reg == ST_DATA || state_reg == ST_STOP) &&
                  (rt_now <= RT_START_S3 || rt_now > RT_BIT_S3); // R10
  assign bit_end = tick && (rt_now == RT_BIT_LAST || (resync && rt_now > RT_BIT_S3)); // R11
  assign start_check = tick && state_reg == ST_START && rt_now == RT_START_S3; // R01
  assign decide = tick && (state_reg == ST_DATA || state_reg == ST_STOP) && rt_now == RT_BIT_S3;
  assign char_done = decide && state_reg == ST_STOP;
  assign char_bit = usr_vote3(vote_in); // R04
  assign addr_wake = rx_standby_ctrl_reg && wake_sel && shift_reg[8]; // R14
  assign accept = !rx_standby_ctrl_reg || addr_wake;

  // receive sequencer
  always_ff @(posedge clock_i) begin
    if (rst_i || !rx_en) begin
      state_reg <= ST_SEARCH;
      rt_cnt_reg <= 5'h00;
      bit_idx_reg <= 4'h0;
    end else if (tick) begin
      case (state_reg)
        ST_SEARCH: begin
          if (!rx && hist_reg == 3'h7) begin // R21
            state_reg <= ST_START;
            rt_cnt_reg <= RT_FIRST;
          end
        end
        ST_START: begin
          if (start_check && usr_ones3(vote_in) >= 2'h2) begin // R03
            state_reg <= ST_SEARCH;
            rt_cnt_reg <= 5'h00;
          end else if (rt_now == RT_BIT_LAST) begin
            state_reg <= ST_DATA;
            rt_cnt_reg <= 5'h00;
            bit_idx_reg <= 4'h0;
          end else begin
            rt_cnt_reg <= rt_now;
          end
        end
        ST_DATA: begin
          if (bit_end) begin
            rt_cnt_reg <= resync ? RT_FIRST : 5'h00;
            bit_idx_reg <= bit_idx_reg + 4'h1;
            if (bit_idx_reg == (char9 ? LAST_BIT_9 : LAST_BIT_8)) begin
              state_reg <= ST_STOP;
            end
          end else if (resync) begin
            rt_cnt_reg <= RT_FIRST; // R10
          end else begin
            rt_cnt_reg <= rt_now;
          end
        end
        ST_STOP: begin
          if (char_done) begin // R11
            state_reg <= ST_SEARCH;
            rt_cnt_reg <= 5'h00;
          end else if (resync) begin
            rt_cnt_reg <= RT_FIRST;
          end else begin
            rt_cnt_reg <= rt_now;
          end
        end
        default: begin
          state_reg <= ST_SEARCH;
          rt_cnt_reg <= 5'h00;
        end
      endcase
    end
  end

  // line history, sample pair and edge tracking
  always_ff @(posedge clock_i) begin
    if (rst_i || !rx_en) begin
      hist_reg <= 3'h0;
      smp_reg <= 2'h0;
      rx_prev_reg <= 1'b1;
      last_bit_reg <= 1'b0;
      shift_reg <= 9'h000;
    end else if (tick) begin
      rx_prev_reg <= rx;
      // cleared when leaving a character so three fresh highs are needed
      hist_reg <= (state_reg == ST_SEARCH) ? {hist_reg[1:0], rx} : 3'h0;
      if ((state_reg == ST_START &&
           (rt_now == RT_START_S1 || rt_now == RT_START_S2)) ||
          (state_reg != ST_SEARCH && (rt_now == RT_BIT_S1 || rt_now == RT_BIT_S2))) begin
        smp_reg <= {smp_reg[0], rx};
      end
      if (state_reg == ST_START) begin
        last_bit_reg <= 1'b0;
      end
      if (decide) begin
        last_bit_reg <= char_bit;
      end
      if (decide && state_reg == ST_DATA) begin
        shift_reg <= char9 ? {char_bit, shift_reg[8:1]} : {char_bit, shift_reg[8:1]};
      end
      if (state_reg == ST_START) begin
        shift_reg <= 9'h000;
      end
    end
  end

  // noise gathered over the whole character
  always_ff @(posedge clock_i) begin
    if (rst_i || !rx_en) begin
      noise_acc_reg <= 1'b0;
    end else if (tick) begin
      if (state_reg == ST_SEARCH) begin
        noise_acc_reg <= 1'b0;
      end else if (start_check && usr_ones3(vote_in) == 2'h1) begin
        noise_acc_reg <= 1'b1; // R02
      end else if (state_reg == ST_START && rx &&
                   rt_now >= RT_BIT_S1 && rt_now <= RT_BIT_S3) begin
        noise_acc_reg <= 1'b1; // R06
      end else if (decide && usr_noise3(vote_in)) begin
        noise_acc_reg <= 1'b1; // R05
      end
    end
  end

  // received word and status flags; hardware set beats a read clear
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      serial_data_buffer_reg <= 9'h000;
      rx_full_flag_reg <= 1'b0;
      framing_error_flag_reg <= 1'b0;
      noise_flag_reg <= 1'b0;
    end else if (char_done && accept) begin
      serial_data_buffer_reg <= char9 ? shift_reg : {1'b0, shift_reg[8:1]};
      rx_full_flag_reg <= 1'b1; // R18
      framing_error_flag_reg <= !char_bit; // R07 R08 R09 R12
      noise_flag_reg <= noise_acc_reg || usr_noise3(vote_in); // R24
    end else if (rd_data) begin
      rx_full_flag_reg <= 1'b0;
      framing_error_flag_reg <= 1'b0;
      noise_flag_reg <= 1'b0;
    end
  end

  // idle run length in oversample ticks
  assign idle_thr = char9 ? IDLE_RT_9 : IDLE_RT_8; // R19
  assign line_idle = idle_cnt_reg == idle_thr;
  assign idle_evt = line_idle && !line_idle_prev_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i || !rx_en) begin
      idle_cnt_reg <= 8'h00;
      line_idle_prev_reg <= 1'b0;
    end else begin
      line_idle_prev_reg <= line_idle;
      if (tick) begin
        if (!rx || state_reg == ST_START ||
            (idle_count_start_sel && state_reg != ST_SEARCH)) begin
          idle_cnt_reg <= 8'h00; // R16 R23
        end else if (!line_idle) begin
          idle_cnt_reg <= idle_cnt_reg + 8'h01;
        end
      end
    end
  end

  // idle flag; a waking idle character leaves it clear
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      idle_flag_reg <= 1'b0;
    end else if (idle_evt && !rx_standby_ctrl_reg) begin
      idle_flag_reg <= 1'b1; // R15 R19
    end else if (rd_stat) begin
      idle_flag_reg <= 1'b0;
    end
  end

  // standby: a software write wins, the wake applies next cycle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_standby_ctrl_reg <= 1'b0;
    end else if (wr_i && addr_i == ADDR_CTRL) begin
      rx_standby_ctrl_reg <= wdata_i[CTRL_STANDBY];
    end else if (char_done && addr_wake) begin
      rx_standby_ctrl_reg <= 1'b0; // R14 R22
    end else if (rx_standby_ctrl_reg && !wake_sel && line_idle) begin
      rx_standby_ctrl_reg <= 1'b0; // R15 R17
    end
  end

  // configuration
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET; // R22 R23
      baud_reg <= RT_DIV_RESET; // R20
    end else if (wr_i) begin
      if (addr_i == ADDR_CTRL) begin
        ctrl_reg <= wdata_i[5:0];
      end
      if (addr_i == ADDR_BAUD) begin
        baud_reg <= wdata_i;
      end
    end
  end

  // read port, data in the following cycle only
  assign rd_stat = rd_i && addr_i == ADDR_STAT;
  assign rd_data = rd_i && addr_i == ADDR_DATA;

  always_ff @(posedge clock_i) begin
    if (rst_i || !rd_i) begin
      rdata_o <= 16'h0000;
    end else begin
      case (addr_i)
        ADDR_CTRL: rdata_o <= {9'h000, rx_standby_ctrl_reg, ctrl_reg};
        ADDR_BAUD: rdata_o <= baud_reg;
        ADDR_STAT: rdata_o <= {11'h000, state_reg != ST_SEARCH, noise_flag_reg,
                               framing_error_flag_reg, idle_flag_reg, rx_full_flag_reg};
        ADDR_DATA: rdata_o <= {7'h00, serial_data_buffer_reg};
        default: rdata_o <= 16'h0000;
      endcase
    end
  end

  // interrupt requests
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_irq_o <= 1'b0;
      idle_irq_o <= 1'b0;
    end else begin
      rx_irq_o <= rx_full_flag_reg && ctrl_reg[CTRL_RXIE] && !rx_standby_ctrl_reg; // R13 R18
      idle_irq_o <= idle_flag_reg && ctrl_reg[CTRL_IDLE_IE] && !rx_standby_ctrl_reg; // R13 R19
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence seq_start_edge;
    tick && state_reg == ST_SEARCH && rx_en && !rx && hist_reg == 3'h7;
  endsequence

  sequence seq_start_ok;
    start_check && usr_ones3(vote_in) <= 2'h1;
  endsequence

  chk_start_edge: assert property (seq_start_edge |=> state_reg == ST_START && rt_cnt_reg == RT_FIRST) // R21
    else $error("start edge not taken");
  chk_start_accept: assert property (seq_start_ok |=> state_reg == ST_START) // R01
    else $error("verified start dropped");
  chk_start_reject: assert property (start_check && usr_ones3(vote_in) >= 2'h2 && rx_en
    |=> state_reg == ST_SEARCH && rt_cnt_reg == 5'h00) // R03
    else $error("failed start not abandoned");
  chk_start_noise: assert property (seq_start_ok ##0 (vote_in != 3'h0) |=> noise_acc_reg) // R02
    else $error("start noise missed");
  chk_start_late_hi: assert property (tick && rx_en && state_reg == ST_START && rx &&
    rt_now == RT_BIT_S2 |=> noise_acc_reg && state_reg == ST_START) // R06
    else $error("late start sample mishandled");
  chk_data_vote: assert property (decide && rx_en |=> last_bit_reg == usr_vote3($past(vote_in))) // R04
    else $error("bit majority wrong");
  chk_data_noise: assert property (decide && rx_en && usr_noise3(vote_in) |=> noise_acc_reg ||
    state_reg == ST_SEARCH) // R05
    else $error("bit noise missed");
  chk_frame_post: assert property (char_done && rx_en && accept && !char_bit
    |=> framing_error_flag_reg && rx_full_flag_reg) // R07 R08 R09
    else $error("framing error not posted with full");
  chk_resync_cnt: assert property (resync && rx_en |=> rt_cnt_reg == RT_FIRST) // R10
    else $error("resync ignored");
  chk_bit_span: assert property (tick && rx_en && state_reg == ST_DATA && rt_now == RT_BIT_LAST
    |=> rt_cnt_reg == 5'h00) // R11
    else $error("bit time not sixteen");
  chk_standby_irq: assert property (rx_standby_ctrl_reg && $past(rx_standby_ctrl_reg)
    |-> !rx_irq_o && !idle_irq_o) // R13
    else $error("interrupt in standby");
  chk_addr_wake: assert property (char_done && rx_en && addr_wake && !wr_i
    |=> !rx_standby_ctrl_reg && rx_full_flag_reg) // R14
    else $error("address mark did not wake");
  chk_idle_wake: assert property (rx_standby_ctrl_reg && !wake_sel && line_idle && !wr_i
    |=> !rx_standby_ctrl_reg && !idle_flag_reg || $past(idle_flag_reg)) // R15 R17
    else $error("idle wake wrong");
  chk_idle_flag: assert property (idle_evt && !rx_standby_ctrl_reg |=> idle_flag_reg) // R19
    else $error("idle flag missed");
endmodule // usr_rx_top

// ===== inc/usr_pkg.sv
package usr_pkg;

  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_DEFAULT = 9600;
  localparam int RT_PER_BIT_N = 16;
  localparam logic [15:0] RT_DIV_RESET = 16'(CLK_HZ / (BAUD_DEFAULT * RT_PER_BIT_N) - 1);

  // oversample positions inside one bit time
  localparam logic [4:0] RT_START_S1 = 5'h03;
  localparam logic [4:0] RT_START_S2 = 5'h05;
  localparam logic [4:0] RT_START_S3 = 5'h07;
  localparam logic [4:0] RT_BIT_S1 = 5'h08;
  localparam logic [4:0] RT_BIT_S2 = 5'h09;
  localparam logic [4:0] RT_BIT_S3 = 5'h0a;
  localparam logic [4:0] RT_BIT_LAST = 5'h10;
  localparam logic [4:0] RT_FIRST = 5'h01;

  // character shape
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [7:0] IDLE_RT_8 = 8'(10 * RT_PER_BIT_N);
  localparam logic [7:0] IDLE_RT_9 = 8'(11 * RT_PER_BIT_N);

  // register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_BAUD = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [3:0] ADDR_DATA = 4'h3;

  // control word fields
  localparam int CTRL_WAKE = 0;
  localparam int CTRL_IDLE_START = 1;
  localparam int CTRL_RXIE = 2;
  localparam int CTRL_IDLE_IE = 3;
  localparam int CTRL_CHAR9 = 4;
  localparam int CTRL_ENABLE = 5;
  localparam int CTRL_STANDBY = 6;
  localparam logic [5:0] CTRL_RESET = 6'h20;

  // status word fields
  localparam int STAT_FULL = 0;
  localparam int STAT_IDLE = 1;
  localparam int STAT_FRAME = 2;
  localparam int STAT_NOISE = 3;
  localparam int STAT_BUSY = 4;

  typedef enum logic [1:0] {
    ST_SEARCH = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b10,
    ST_STOP = 2'b11
  } usr_rx_state_t;

  function automatic logic [1:0] usr_ones3(input logic [2:0] v);
    usr_ones3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
  endfunction

  function automatic logic usr_vote3(input logic [2:0] v);
    usr_vote3 = usr_ones3(v) >= 2'h2;
  endfunction

  function automatic logic usr_noise3(input logic [2:0] v);
    usr_noise3 = (v != 3'h0) && (v != 3'h7);
  endfunction

endpackage

// ===== rtl/usr_sync2.sv
`timescale 1ns/100ps
module usr_sync2 (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // line
  input wire logic d_i,
  output logic q_o
);
  logic meta_reg;

  // resets high: an idle serial line is high
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_reg <= 1'b1;
      q_o <= 1'b1;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule // usr_sync2

// ===== rtl/usr_rt_div.sv
`timescale 1ns/100ps
module usr_rt_div (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // control
  input wire logic en_i,
  input wire logic [15:0] div_i,
  // oversample enable
  output logic tick_o
);
  logic [15:0] cnt_reg;

  // one pulse every div_i+1 clocks
  always_ff @(posedge clock_i) begin
    if (rst_i || !en_i) begin
      cnt_reg <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt_reg >= div_i) begin
      cnt_reg <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule // usr_rt_div

// ===== dv/usr_tx_model.sv
`timescale 1ns/100ps
module usr_tx_model (
  // clock
  input wire logic clock_i,
  // serial line toward the receiver
  output logic rxd_o
);
  // line idles high between frames, like a released line with its pull-up
  initial rxd_o = 1'b1;

  // one line level per clock; bit length and glitches are built by the caller
  task automatic play(input logic wv[$]);
    foreach (wv[i]) begin
      @(posedge clock_i);
      rxd_o <= wv[i];
    end
    @(posedge clock_i);
    rxd_o <= 1'b1;
  endtask
endmodule // usr_tx_model

// ===== dv/tb.sv
`timescale 1ns/100ps
module tb import usr_pkg::*; ;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic rxd;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic rx_irq_o;
  logic idle_irq_o;
  int fails = 0;
  int tests_run = 0;
  int seed = 89;
  logic wv[$];
  logic [15:0] v;
  logic [8:0] d;
  int n;
  // glitch positions in ticks from the start edge; -2 marks a break
  int flip_a[12] = '{-1, 2, 4, 6, 7, 56, 55, 151, 152, 151, -2, -1};
  int flip_b[12] = '{-1, -1, -1, -1, 9, -1, 57, -1, -1, 152, -1, -1};

  always #50 clock_i = ~clock_i;

  usr_rx_top usr_rx_top_i (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .rxd_i(rxd),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .rx_irq_o(rx_irq_o),
    .idle_irq_o(idle_irq_o)
  );

  usr_tx_model usr_tx_model_i (
    .clock_i(clock_i),
    .rxd_o(rxd)
  );

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] dat);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= dat;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e,
                        input string nm);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    v = rdata_o;
    check(nm, v & m, e);
  endtask

  // start, nb data bits lsb first, stop; len clocks per bit
  task automatic build(input logic [8:0] dat, input int nb, input logic stop, input int len);
    wv.delete();
    for (int b = 0; b < nb + 2; b++) begin
      for (int k = 0; k < len; k++) begin
        wv.push_back(b == 0 ? 1'b0 : (b > nb ? stop : dat[b-1]));
      end
    end
  endtask

  // reference receiver on an ideally timed frame: {noise, framing, data}
  function automatic logic [10:0] predict(input int nb);
    int c;
    logic nf;
    logic fe;
    logic [8:0] dd;
    nf = (wv[2] + wv[4] + wv[6]) == 1 || wv[7] || wv[8] || wv[9];
    dd = 9'h000;
    fe = 1'b0;
    for (int b = 1; b <= nb + 1; b++) begin
      c = wv[16*b+7] + wv[16*b+8] + wv[16*b+9];
      nf = nf | (c == 1 || c == 2);
      if (b <= nb)
        dd[b-1] = (c >= 2);
      else
        fe = (c < 2);
    end
    return {nf, fe, dd};
  endfunction

  task automatic frame(input int nb, input logic [10:0] e);
    usr_tx_model_i.play(wv);
    repeat (6) @(posedge clock_i);
    check("rx_irq_o", {15'h0000, rx_irq_o}, 16'h0001);
    chk_rd(ADDR_STAT, 16'h000d, {12'h000, e[10:9], 2'b01}, "status");
    chk_rd(ADDR_DATA, {7'h00, nb == 9, 8'hff}, {7'h00, e[8:0]}, "data");
    repeat (2) @(posedge clock_i);
    check("rx_irq_o", {15'h0000, rx_irq_o}, 16'h0000);
  endtask

  initial begin
    #2_000_000;
    fails++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    chk_rd(ADDR_CTRL, 16'hffff, 16'h0020, "ctrl reset");
    chk_rd(ADDR_BAUD, 16'hffff, 16'h0040, "baud reset");
    chk_rd(ADDR_STAT, 16'hffff, 16'h0000, "status reset");
    wr(4'h9, 16'hffff);
    chk_rd(4'h9, 16'hffff, 16'h0000, "unmapped");
    // tick every clock keeps each character at 16 clocks per bit
    wr(ADDR_BAUD, 16'h0000);
    chk_rd(ADDR_BAUD, 16'hffff, 16'h0000, "baud");
    wr(ADDR_CTRL, 16'h0024);
    // samples 011 refuse the start, nothing posts
    wv.delete();
    repeat (3) wv.push_back(1'b0);
    repeat (30) wv.push_back(1'b1);
    usr_tx_model_i.play(wv);
    repeat (6) @(posedge clock_i);
    chk_rd(ADDR_STAT, 16'h0001, 16'h0000, "false start");
    for (int i = 0; i < 12; i++) begin
      n = (i == 11) ? 9 : 8;
      if (i == 11)
        wr(ADDR_CTRL, 16'h0034);
      d = (flip_a[i] == -2) ? 9'h000 : 9'($random(seed));
      build(d, n, flip_a[i] != -2, 16);
      if (flip_a[i] >= 0)
        wv[flip_a[i]] = ~wv[flip_a[i]];
      if (flip_b[i] >= 0)
        wv[flip_b[i]] = ~wv[flip_b[i]];
      frame(n, predict(n));
    end
    // slow sender, 17 clocks per bit, only resync keeps it clean
    wr(ADDR_CTRL, 16'h0024);
    build(9'h055, 8, 1, 17);
    frame(8, 11'h055);
    wr(ADDR_CTRL, 16'h0028);
    build(9'h0ff, 8, 1, 16);
    usr_tx_model_i.play(wv);
    repeat (40) @(posedge clock_i);
    check("idle_irq_o", {15'h0000, idle_irq_o}, 16'h0001);
    chk_rd(ADDR_STAT, 16'h0002, 16'h0002, "idle flag");
    chk_rd(ADDR_DATA, 16'h00ff, 16'h00ff, "data");
    wr(ADDR_CTRL, 16'h002a);
    usr_tx_model_i.play(wv);
    repeat (100) @(posedge clock_i);
    check("idle_irq_o", {15'h0000, idle_irq_o}, 16'h0000);
    repeat (100) @(posedge clock_i);
    check("idle_irq_o", {15'h0000, idle_irq_o}, 16'h0001);
    // full still pending: standby must hide its request
    wr(ADDR_CTRL, 16'h0065);
    repeat (3) @(posedge clock_i);
    check("rx_irq_o", {15'h0000, rx_irq_o}, 16'h0000);
    build(9'h012, 8, 1, 16);
    usr_tx_model_i.play(wv);
    repeat (6) @(posedge clock_i);
    chk_rd(ADDR_DATA, 16'h00ff, 16'h00ff, "dropped char");
    d = {2'b01, 7'($random(seed))};
    build(d, 8, 1, 16);
    frame(8, predict(8));
    chk_rd(ADDR_CTRL, 16'h0040, 16'h0000, "standby");
    repeat (200) @(posedge clock_i);
    chk_rd(ADDR_STAT, 16'h000f, 16'h0002, "status clear");
    wr(ADDR_CTRL, 16'h0064);
    repeat (5) @(posedge clock_i);
    chk_rd(ADDR_CTRL, 16'h0040, 16'h0000, "standby");
    build(9'h012, 8, 1, 16);
    fork
      usr_tx_model_i.play(wv);
      begin
        repeat (20) @(posedge clock_i);
        wr(ADDR_CTRL, 16'h006c);
      end
    join
    repeat (250) @(posedge clock_i);
    chk_rd(ADDR_CTRL, 16'h0040, 16'h0000, "standby");
    check("idle_irq_o", {15'h0000, idle_irq_o}, 16'h0000);
    chk_rd(ADDR_STAT, 16'h0003, 16'h0000, "idle full");
    complete_run();
  end
endmodule // tb
